// [nrs_unit.v]
// Execution unit for nibble rotate, restart, subtract with borrow and set-carry
`timescale 1ns/1ps
`include "nrs_defines.vh"
module nrs_unit (
   // Clock and reset
   input wire clk_in,
   input wire srst_in,
   // Instruction request
   input wire start_in,
   input wire [2:0] op_in,
   input wire [1:0] src_mode_in,
   input wire [2:0] field_in,
   input wire [1:0] pair_in,
   input wire [7:0] imm_in,
   input wire [7:0] disp_in,
   input wire idx_sel_in,
   // Architectural state loading
   input wire load_in,
   input wire [7:0] load_a_in,
   input wire [7:0] load_f_in,
   input wire [15:0] load_bc_in,
   input wire [15:0] load_de_in,
   input wire [15:0] load_pointer_pair_in,
   input wire [15:0] load_sp_in,
   input wire [15:0] load_pc_in,
   input wire [15:0] load_index_reg_first_in,
   input wire [15:0] load_index_reg_second_in,
   // Memory read data
   input wire [7:0] mem_rdata_in,
   // Memory access
   output reg [15:0] mem_addr_out,
   output reg [7:0] mem_wdata_out,
   output reg mem_rd_out,
   output reg mem_wr_out,
   // Status and state
   output wire busy_out,
   output reg done_out,
   output reg [7:0] acc_out,
   output reg [7:0] flags_out,
   output reg [15:0] bc_out,
   output reg [15:0] de_out,
   output reg [15:0] pointer_pair_out,
   output reg [15:0] sp_out,
   output reg [15:0] pc_out
);
   reg [15:0] index_reg_first_r;
   reg [15:0] index_reg_second_r;
   reg [4:0] cnt_r;
   reg [4:0] len_r;
   reg [2:0] op_r;
   reg [1:0] src_r;
   reg [2:0] fld_r;
   reg [1:0] pair_r;
   reg [7:0] imm_r;
   reg [15:0] eaddr_r;
   reg [7:0] mem_r;
   wire carry_flag = flags_out[`NRS_FC];
   wire active = (op_r != `NRS_OP_NONE);
   assign busy_out = active;
   // Register select, code 110 reads as zero; the memory operand comes from the source mode
   reg [7:0] reg_val;
   always @* begin
      case (fld_r)
         3'h0: reg_val = bc_out[15:8];
         3'h1: reg_val = bc_out[7:0];
         3'h2: reg_val = de_out[15:8];
         3'h3: reg_val = de_out[7:0];
         3'h4: reg_val = pointer_pair_out[15:8];
         3'h5: reg_val = pointer_pair_out[7:0];
         3'h7: reg_val = acc_out;
         default: reg_val = 8'h00;
      endcase
   end
   reg [7:0] opnd;
   always @* begin
      case (src_r)
         `NRS_SRC_REG: opnd = reg_val;
         `NRS_SRC_IMM: opnd = imm_r;
         default: opnd = mem_r;
      endcase
   end
   // 8-bit subtract with borrow
   wire [8:0] d8 = {1'b0, acc_out} - {1'b0, opnd} - {8'h00, carry_flag};
   wire [4:0] d4 = {1'b0, acc_out[3:0]} - {1'b0, opnd[3:0]} - {4'h0, carry_flag};
   wire v8 = (acc_out[7] ^ opnd[7]) & (acc_out[7] ^ d8[7]);
   reg [15:0] pr_val;
   always @* begin
      case (pair_r)
         2'h0: pr_val = bc_out;
         2'h1: pr_val = de_out;
         2'h2: pr_val = pointer_pair_out;
         default: pr_val = sp_out;
      endcase
   end
   wire [16:0] d16 = {1'b0, pointer_pair_out} - {1'b0, pr_val} - {16'h0000, carry_flag};
   wire [12:0] d12 = {1'b0, pointer_pair_out[11:0]} - {1'b0, pr_val[11:0]} -
                     {12'h000, carry_flag};
   wire v16 = (pointer_pair_out[15] ^ pr_val[15]) & (pointer_pair_out[15] ^ d16[15]);
   wire [7:0] rot_a = {acc_out[7:4], mem_r[3:0]};
   wire [7:0] rot_m = {acc_out[3:0], mem_r[7:4]};
   wire [7:0] ora = acc_out | acc_out;
   wire last = active && (cnt_r == len_r - 5'h01);
   reg [4:0] len_sel;
   always @* begin
      case (op_in)
         `NRS_OP_NIB_ROT: len_sel = `NRS_ST_NIB_ROT;
         `NRS_OP_RST: len_sel = `NRS_ST_RST;
         `NRS_OP_SUB8: begin
            case (src_mode_in)
               `NRS_SRC_REG: len_sel = `NRS_ST_SUB_REG;
               `NRS_SRC_IDX: len_sel = `NRS_ST_SUB_IDX;
               default: len_sel = `NRS_ST_SUB_MEM;
            endcase
         end
         `NRS_OP_SUB16: len_sel = `NRS_ST_SUB16;
         `NRS_OP_FORCE_C: len_sel = `NRS_ST_FORCE_C;
         `NRS_OP_ORA: len_sel = `NRS_ST_ORA;
         default: len_sel = 5'h01;
      endcase
   end
   wire [15:0] idx_base = idx_sel_in ? index_reg_second_r : index_reg_first_r;
   wire [15:0] idx_addr = idx_base + {{8{disp_in[7]}}, disp_in};
   wire need_mem = (op_in == `NRS_OP_NIB_ROT) ||
                   ((op_in == `NRS_OP_SUB8) &&
                    (src_mode_in == `NRS_SRC_PTR || src_mode_in == `NRS_SRC_IDX));
   // Memory read happens at state 2 counted from the start of the instruction; result lands at the end
   wire rd_now = active && (cnt_r == `NRS_CNT_RD) && (op_r == `NRS_OP_NIB_ROT ||
                 (op_r == `NRS_OP_SUB8 && src_r != `NRS_SRC_REG && src_r != `NRS_SRC_IMM));
   always @(posedge clk_in) begin
      if (srst_in) begin
         op_r <= `NRS_OP_NONE;
         cnt_r <= 5'd0;
         len_r <= 5'd1;
         src_r <= 2'h0;
         fld_r <= 3'h0;
         pair_r <= 2'h0;
         imm_r <= 8'h00;
         eaddr_r <= 16'h0000;
         mem_r <= 8'h00;
         mem_addr_out <= 16'h0000;
         mem_wdata_out <= 8'h00;
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         done_out <= 1'b0;
         acc_out <= 8'h00;
         flags_out <= `NRS_RST_F;
         bc_out <= 16'h0000;
         de_out <= 16'h0000;
         pointer_pair_out <= 16'h0000;
         sp_out <= `NRS_RST_SP;
         pc_out <= 16'h0000;
         index_reg_first_r <= 16'h0000;
         index_reg_second_r <= 16'h0000;
      end else begin
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         done_out <= 1'b0;
         if (!active) begin
            if (load_in) begin
               acc_out <= load_a_in;
               flags_out <= load_f_in;
               bc_out <= load_bc_in;
               de_out <= load_de_in;
               pointer_pair_out <= load_pointer_pair_in;
               sp_out <= load_sp_in;
               pc_out <= load_pc_in;
               index_reg_first_r <= load_index_reg_first_in;
               index_reg_second_r <= load_index_reg_second_in;
            end else if (start_in && op_in != `NRS_OP_NONE && op_in != 3'h7) begin
               op_r <= op_in;
               len_r <= len_sel;
               cnt_r <= 5'd0;
               src_r <= src_mode_in;
               fld_r <= field_in;
               pair_r <= pair_in;
               imm_r <= imm_in;
               eaddr_r <= (op_in == `NRS_OP_SUB8 && src_mode_in == `NRS_SRC_IDX) ?
                          idx_addr : pointer_pair_out;
               if (need_mem) begin
                  mem_addr_out <= (op_in == `NRS_OP_SUB8 && src_mode_in == `NRS_SRC_IDX) ?
                                  idx_addr : pointer_pair_out;
               end
            end
         end else begin
            cnt_r <= cnt_r + 5'd1;
            if (rd_now) begin
               mem_rd_out <= 1'b1;
               mem_r <= mem_rdata_in;
            end
            // Restart push: predecrement, high byte first, then low
            if (op_r == `NRS_OP_RST) begin
               if (cnt_r == `NRS_CNT_PUSH_HI) begin
                  sp_out <= sp_out - 16'h0001;
                  mem_addr_out <= sp_out - 16'h0001;
                  mem_wdata_out <= pc_out[15:8];
                  mem_wr_out <= 1'b1;
               end
               if (cnt_r == `NRS_CNT_PUSH_LO) begin
                  sp_out <= sp_out - 16'h0001;
                  mem_addr_out <= sp_out - 16'h0001;
                  mem_wdata_out <= pc_out[7:0];
                  mem_wr_out <= 1'b1;
               end
            end
            // Nibble rotate write back in the final 3-state cycle
            if (op_r == `NRS_OP_NIB_ROT && cnt_r == `NRS_CNT_ROT_WR) begin
               mem_addr_out <= eaddr_r;
               mem_wdata_out <= rot_m;
               mem_wr_out <= 1'b1;
            end
            if (last) begin
               op_r <= `NRS_OP_NONE;
               done_out <= 1'b1;
               case (op_r)
                  `NRS_OP_NIB_ROT: begin
                     acc_out <= rot_a;
                     flags_out[`NRS_FS] <= rot_a[7];
                     flags_out[`NRS_FZ] <= (rot_a == 8'h00);
                     flags_out[`NRS_FPV] <= ~^rot_a;
                     flags_out[`NRS_FH] <= 1'b0;
                     flags_out[`NRS_FN] <= 1'b0;
                  end
                  `NRS_OP_RST: begin
                     pc_out <= {8'h00, {2'b00, fld_r} * `NRS_VEC_STEP};
                  end
                  `NRS_OP_SUB8: begin
                     acc_out <= d8[7:0];
                     flags_out[`NRS_FS] <= d8[7];
                     flags_out[`NRS_FZ] <= (d8[7:0] == 8'h00);
                     flags_out[`NRS_FH] <= d4[4];
                     flags_out[`NRS_FPV] <= v8;
                     flags_out[`NRS_FN] <= 1'b1;
                     flags_out[`NRS_FC] <= d8[8];
                  end
                  `NRS_OP_SUB16: begin
                     pointer_pair_out <= d16[15:0];
                     flags_out[`NRS_FS] <= d16[15];
                     flags_out[`NRS_FZ] <= (d16[15:0] == 16'h0000);
                     flags_out[`NRS_FH] <= d12[12];
                     flags_out[`NRS_FPV] <= v16;
                     flags_out[`NRS_FN] <= 1'b1;
                     flags_out[`NRS_FC] <= d16[16];
                  end
                  `NRS_OP_FORCE_C: begin
                     flags_out[`NRS_FC] <= 1'b1;
                     flags_out[`NRS_FH] <= 1'b0;
                     flags_out[`NRS_FN] <= 1'b0;
                  end
                  `NRS_OP_ORA: begin
                     acc_out <= ora;
                     flags_out[`NRS_FS] <= ora[7];
                     flags_out[`NRS_FZ] <= (ora == 8'h00);
                     flags_out[`NRS_FH] <= 1'b0;
                     flags_out[`NRS_FPV] <= ~^ora;
                     flags_out[`NRS_FN] <= 1'b0;
                     flags_out[`NRS_FC] <= 1'b0;
                  end
                  default: op_r <= `NRS_OP_NONE;
               endcase
            end
         end
      end
   end
endmodule // nrs_unit

// [nrs_defines.vh]
// Constants for the nibble rotate, restart, subtract with borrow and set-carry unit
// Behaviour
// - Memory low nibble goes to accumulator low
// - Accumulator low to memory high; memory high to low
// - Accumulator high nibble kept by nibble rotate
// - Nibble rotate takes 4 cycles, 16 states
// - Rotate flags from A; H, N cleared
// - Restart pushes PC high then low, predecrementing
// - Restart loads PC with vector field times 08H
// - Restart takes 3 cycles, 11 states, then fetch
// - 8-bit subtract: A minus operand minus carry
// - Register select codes B..L, A is 111
// - Subtract states: 4 reg, 6 imm/ptr, 14 indexed
// - Byte subtract: borrow flags H, C; N set
// - 16-bit subtract: pointer minus pair minus carry
// - Pair select BC DE pointer stack pointer
// - Wide subtract: H borrows bit 12, N set
// - Force carry sets C, clears H N
`ifndef NRS_DEFINES_VH
`define NRS_DEFINES_VH
`define NRS_OP_NONE 3'h0
`define NRS_OP_NIB_ROT 3'h1
`define NRS_OP_RST 3'h2
`define NRS_OP_SUB8 3'h3
`define NRS_OP_SUB16 3'h4
`define NRS_OP_FORCE_C 3'h5
`define NRS_OP_ORA 3'h6
`define NRS_SRC_REG 2'h0
`define NRS_SRC_IMM 2'h1
`define NRS_SRC_PTR 2'h2
`define NRS_SRC_IDX 2'h3
`define NRS_ST_NIB_ROT 5'h10
`define NRS_ST_RST 5'h0B
`define NRS_ST_SUB_REG 5'h04
`define NRS_ST_SUB_MEM 5'h06
`define NRS_ST_SUB_IDX 5'h0E
`define NRS_ST_SUB16 5'h0A
`define NRS_ST_FORCE_C 5'h03
`define NRS_ST_ORA 5'h04
`define NRS_CNT_RD 5'h02
`define NRS_CNT_PUSH_HI 5'h04
`define NRS_CNT_PUSH_LO 5'h07
`define NRS_CNT_ROT_WR 5'h0E
`define NRS_FS 7
`define NRS_FZ 6
`define NRS_FH 4
`define NRS_FPV 2
`define NRS_FN 1
`define NRS_FC 0
`define NRS_VEC_STEP 8'h08
`define NRS_RST_F 8'h00
`define NRS_RST_SP 16'hFFFF
`endif

// [nrs_mem_model.sv]
// Behavioural memory holding operands and the stack
`timescale 1ns/1ps
module nrs_mem_model (
   // Clock
   input wire clk_in,
   // Access from the unit
   input wire [15:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   // Read data
   output wire [7:0] rdata_out
);
   reg [7:0] mem [0:65535];
   // Read data follows the address combinationally, as the unit samples it early
   assign rdata_out = mem[addr_in];
   always @(posedge clk_in) begin
      if (wr_in) begin
         mem[addr_in] <= wdata_in;
      end
   end
endmodule // nrs_mem_model

// [nrs_unit_props.sv]
// Timing and flag checks on the unit's ports
`timescale 1ns/1ps
module nrs_unit_props (
   input wire clk_in,
   input wire srst_in,
   input wire start_in,
   input wire [2:0] op_in,
   input wire [1:0] src_mode_in,
   input wire [2:0] field_in,
   input wire load_in,
   input wire [7:0] mem_wdata_out,
   input wire mem_wr_out,
   input wire mem_rd_out,
   input wire busy_out,
   input wire done_out,
   input wire [7:0] acc_out,
   input wire [7:0] flags_out,
   input wire [15:0] pc_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence s_go(logic [2:0] o);
      start_in && !busy_out && !load_in && op_in == o;
   endsequence
   sequence s_push;
      ##[1:10] (mem_wr_out && mem_wdata_out == pc_out[15:8])
      ##[1:9] (mem_wr_out && mem_wdata_out == pc_out[7:0]);
   endsequence
   sequence s_sub(logic [1:0] s);
      start_in && !busy_out && !load_in && op_in == 3'h3 && src_mode_in == s;
   endsequence
   // Last busy state, then the one-cycle done pulse with state updated
   sequence s_finish;
      (busy_out && !done_out) ##1 done_out;
   endsequence
   a_rotate_time: assert property (s_go(3'h1) |-> ##16 s_finish)
      else $error("nibble rotate not done in 16 states");
   a_rotate_read: assert property (s_go(3'h1) |-> ##4 mem_rd_out)
      else $error("nibble rotate did not read its operand");
   a_rotate_keep: assert property (s_go(3'h1) |-> ##17 acc_out[7:4] ==
      $past(acc_out[7:4], 17) && flags_out[0] == $past(flags_out[0], 17))
      else $error("nibble rotate changed high nibble or carry");
   a_restart_time: assert property (s_go(3'h2) |-> ##11 s_finish)
      else $error("restart not done in 11 states");
   a_restart_push: assert property (s_go(3'h2) |-> s_push)
      else $error("restart push order wrong");
   a_restart_vec: assert property (s_go(3'h2) |->
      ##12 pc_out == {8'h00, $past(field_in, 12), 3'h0})
      else $error("restart vector wrong");
   a_sub_reg_time: assert property (s_sub(2'h0) |-> ##4 s_finish)
      else $error("register subtract not done in 4 states");
   a_sub_imm_time: assert property (s_sub(2'h1) |-> ##6 s_finish)
      else $error("immediate subtract not done in 6 states");
   a_sub_ptr_time: assert property (s_sub(2'h2) |-> ##6 s_finish)
      else $error("pointer subtract not done in 6 states");
   a_sub_idx_time: assert property (s_sub(2'h3) |-> ##14 s_finish)
      else $error("indexed subtract not done in 14 states");
   a_wide_sub_flag: assert property (s_go(3'h4) |-> ##10 s_finish ##0 flags_out[1])
      else $error("wide subtract timing or flag wrong");
   a_force_carry: assert property (s_go(3'h5) |-> ##3 s_finish ##0 (flags_out[0] &&
      flags_out[4:1] == {1'b0, $past(flags_out[3:2], 4), 1'b0} &&
      flags_out[7:6] == $past(flags_out[7:6], 4)))
      else $error("force carry result wrong");
endmodule // nrs_unit_props
bind nrs_unit nrs_unit_props u_props (.clk_in(clk_in), .srst_in(srst_in), .start_in(start_in),
   .op_in(op_in), .src_mode_in(src_mode_in), .field_in(field_in), .load_in(load_in),
   .mem_wdata_out(mem_wdata_out), .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out),
   .busy_out(busy_out), .done_out(done_out), .acc_out(acc_out), .flags_out(flags_out),
   .pc_out(pc_out));

// [tb_nibble_restart_subtract_ops.sv]
// Self-checking testbench for the execution unit
`timescale 1ns/1ps
module tb_nibble_restart_subtract_ops;
   reg clk = 0, srst = 1, start = 0, ld = 0, isel = 0;
   reg [2:0] op = 0, fld = 0;
   reg [1:0] src = 0, pair = 0;
   reg [7:0] imm = 0, disp = 0, la = 0, lf = 0;
   reg [15:0] lbc = 0, lde = 0, lptr = 0, lsp = 0, lpc = 0, lix = 0, liy = 0;
   wire [7:0] rdata, wdata, acc, flags;
   wire [15:0] addr, bc, de, ptr, sp, pc;
   wire rd, wr, busy, done;
   integer errors = 0, total_checks = 0, i;
   reg [7:0] v;
   reg [15:0] e;
   nrs_unit u_dut (.clk_in(clk), .srst_in(srst), .start_in(start), .op_in(op),
      .src_mode_in(src), .field_in(fld), .pair_in(pair), .imm_in(imm), .disp_in(disp),
      .idx_sel_in(isel), .load_in(ld), .load_a_in(la), .load_f_in(lf), .load_bc_in(lbc),
      .load_de_in(lde), .load_pointer_pair_in(lptr), .load_sp_in(lsp), .load_pc_in(lpc),
      .load_index_reg_first_in(lix), .load_index_reg_second_in(liy),
      .mem_rdata_in(rdata), .mem_addr_out(addr),
      .mem_wdata_out(wdata), .mem_rd_out(rd), .mem_wr_out(wr), .busy_out(busy),
      .done_out(done), .acc_out(acc), .flags_out(flags), .bc_out(bc), .de_out(de),
      .pointer_pair_out(ptr), .sp_out(sp), .pc_out(pc));
   nrs_mem_model u_mem (.clk_in(clk), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
      .rdata_out(rdata));
   initial begin
      forever #20 clk = ~clk;
   end
   task chk(input [15:0] seen, input [15:0] exp, input [8*12-1:0] msg);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("FAIL %0t %0s seen %h expected %h", $time, msg, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task load;
      begin
         @(posedge clk); #1 ld = 1;
         @(posedge clk); #1 ld = 0;
      end
   endtask
   task go(input [2:0] o, input [1:0] s);
      integer n;
      begin
         @(posedge clk); #1 start = 1; op = o; src = s;
         @(posedge clk); #1 start = 0;
         n = 0;
         while (done !== 1'b1 && n < 40) begin
            @(posedge clk); #1 n = n + 1;
         end
         chk(n < 40, 1, "no done");
      end
   endtask
   // Expected {flags, result} of a byte subtract with borrow; undefined bits 5 and 3 zero
   function [15:0] f8(input [7:0] a, input [7:0] b, input c);
      reg [8:0] d;
      begin
         d = {1'b0, a} - b - c;
         f8 = {d[7], d[7:0] == 0, 1'b0, {1'b0, a[3:0]} < b[3:0] + c, 1'b0,
            a[7] != b[7] && d[7] != a[7], 1'b1, d[8], d[7:0]};
      end
   endfunction
   function [23:0] f16(input [15:0] a, input [15:0] b, input c);
      reg [16:0] d;
      begin
         d = {1'b0, a} - b - c;
         f16 = {d[15], d[15:0] == 0, 1'b0, {1'b0, a[11:0]} < b[11:0] + c, 1'b0,
            a[15] != b[15] && d[15] != a[15], 1'b1, d[16], d[15:0]};
      end
   endfunction
   task t_rotate;
      begin
         la = 8'h7A; lf = 8'h01; lptr = 16'h5000; u_mem.mem[16'h5000] = 8'h31; load;
         go(3'h1, 2'h0);
         chk(acc, 8'h71, "rotate acc");
         chk(u_mem.mem[16'h5000], 8'hA3, "rotate mem");
         chk(flags & 8'hD7, 8'h05, "rotate flg");
         $display("test rotate done");
      end
   endtask
   task t_restart;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            lpc = 16'h15B3; lsp = 16'h1000; fld = i; load;
            go(3'h2, 2'h0);
            chk({u_mem.mem[16'h0FFF], u_mem.mem[16'h0FFE]}, 16'h15B3, "push");
            chk(sp, 16'h0FFE, "stack ptr");
            chk(pc, i * 8, "vector");
         end
         $display("test restart done");
      end
   endtask
   task t_sub8;
      begin
         la = 8'h16; lf = 8'h01; lbc = 16'h0102; lde = 16'h0304; lptr = 16'h0506;
         for (i = 0; i < 8; i = i + 1) if (i != 6) begin
            fld = i; load;
            v = i == 7 ? 8'h16 : i + 1;
            go(3'h3, 2'h0);
            e = f8(8'h16, v, 1'b1);
            chk({flags & 8'hD7, acc}, e, "sub reg");
         end
         u_mem.mem[16'h3433] = 8'h05; imm = 8'h05; lptr = 16'h3433;
         lix = 16'h3440; liy = 16'h3400;
         for (i = 1; i < 5; i = i + 1) begin
            isel = i == 4; disp = i == 4 ? 8'h33 : 8'hF3; load;
            go(3'h3, i == 4 ? 2'h3 : i);
            chk({flags & 8'hD7, acc}, f8(8'h16, 8'h05, 1'b1), "sub mem");
         end
         $display("test subtract done");
      end
   endtask
   task t_sub16;
      reg [23:0] x;
      begin
         lbc = 16'h1234; lde = 16'h1111; lsp = 16'h8000; lptr = 16'h9999; lf = 8'h01;
         for (i = 0; i < 4; i = i + 1) begin
            pair = i; load;
            e = i == 0 ? lbc : i == 1 ? lde : i == 2 ? lptr : lsp;
            x = f16(16'h9999, e, 1'b1);
            go(3'h4, 2'h0);
            chk(ptr, x[15:0], "wide res");
            chk(flags & 8'hD7, x[23:16], "wide flg");
         end
         $display("test wide subtract done");
      end
   endtask
   task t_carry;
      begin
         la = 8'h80; lf = 8'hD6; load;
         go(3'h5, 2'h0);
         chk(flags & 8'hD7, 8'hC5, "force carry");
         go(3'h6, 2'h0);
         chk(flags & 8'hD7, 8'h80, "clear carry");
         $display("test carry done");
      end
   endtask
   initial begin
      #800000 errors = errors + 1;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 srst = 0;
      t_rotate;
      t_restart;
      t_sub8;
      t_sub16;
      t_carry;
      give_verdict;
   end
endmodule // tb_nibble_restart_subtract_ops
